// file: hdl/hbp_host_port.sv
// Host bus pin decode: qualification, latching, strobes, straps, sleep
module hbp_host_port #(
   parameter bit IS_32BIT = 1'b0
) (
   input wire logic i_clk_sys,
   input wire logic i_hw_reset_n,
   input wire logic [15:1] i_addr,
   input wire logic i_addr_qualifier_n,
   input wire logic i_addr_latch_strobe_n,
   input wire logic i_write_strobe_n,
   input wire logic i_read_strobe_n,
   input wire logic i_sync_req,
   input wire logic i_sync_dir,
   input wire logic i_chip_sleep_n,
   input wire logic i_eeprom_present_strap,
   input wire logic i_eeprom_serial_in,
   input wire logic i_ee_shift,
   input wire logic [7:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [15:0] o_reg_rdata,
   output logic o_local_select_n,
   output hbp_pkg::hbp_acc_t o_acc,
   output hbp_pkg::hbp_width_t o_bus_width,
   output logic o_eeprom_used,
   output logic o_sleep
);
   logic latch_en;
   logic [11:0] base;
   logic [15:0] ee_data;
   logic straps_taken;
   logic ee_strap;
   hbp_pkg::hbp_width_t width;
   logic [15:1] lat_addr;
   logic lat_qual_n;
   logic ads_prev;
   logic wr_prev;
   logic rd_prev;
   hbp_pkg::hbp_acc_t acc;
   logic [15:0] rdata;

   // Address path: latched copy or live pins
   wire [15:1] dec_addr = latch_en ? lat_addr : i_addr;
   wire dec_qual_n = latch_en ? lat_qual_n : i_addr_qualifier_n;
   wire hit = !dec_qual_n && (dec_addr[15:4] == base);
   wire ads_rise = !ads_prev && i_addr_latch_strobe_n;
   // Falling edge of the write or read strobe opens one access window
   wire wr_open = wr_prev && !i_write_strobe_n;
   wire rd_open = rd_prev && !i_read_strobe_n;
   wire sleeping = !i_chip_sleep_n;
   wire go = hit && !sleeping;
   wire next_wr = go && (wr_open || (i_sync_req && i_sync_dir));
   wire next_rd = go && (rd_open || (i_sync_req && !i_sync_dir));

   assign o_local_select_n = !hit;
   assign o_sleep = sleeping;
   assign o_acc = acc;
   assign o_bus_width = width;
   assign o_eeprom_used = ee_strap;
   assign o_reg_rdata = rdata;

   // Register port decode
   wire wr_ctrl = i_reg_wr && (i_reg_addr == hbp_pkg::REG_CTRL);
   wire wr_base = i_reg_wr && (i_reg_addr == hbp_pkg::REG_BASE);
   logic [15:0] stat_word;
   always_comb begin
      stat_word = 16'h0000;
      stat_word[hbp_pkg::STAT_EE_BIT] = ee_strap;
      stat_word[hbp_pkg::STAT_WIDTH_LSB +: 2] = width;
      stat_word[hbp_pkg::STAT_SLEEP_BIT] = sleeping;
      stat_word[hbp_pkg::STAT_QUAL_BIT] = dec_qual_n;
   end
   wire [15:0] next_rdata =
      !i_reg_rd ? 16'h0000 :
      (i_reg_addr == hbp_pkg::REG_CTRL) ? {15'h0000, latch_en} :
      (i_reg_addr == hbp_pkg::REG_BASE) ? {base, 4'h0} :
      (i_reg_addr == hbp_pkg::REG_STAT) ? stat_word :
      (i_reg_addr == hbp_pkg::REG_EEDATA) ? ee_data : 16'h0000;

   // Straps are sampled once, the first edge after reset release
   wire hbp_pkg::hbp_width_t strap_width =
      IS_32BIT ? hbp_pkg::HBP_W32 :
      (i_eeprom_serial_in ? hbp_pkg::HBP_W16 : hbp_pkg::HBP_W8);

   always_ff @(posedge i_clk_sys or negedge i_hw_reset_n) begin
      if (!i_hw_reset_n) begin
         straps_taken <= 1'b0;
         ee_strap <= 1'b0;
         width <= hbp_pkg::HBP_W8;
      end else if (!straps_taken) begin
         straps_taken <= 1'b1;
         ee_strap <= i_eeprom_present_strap;
         // With EEPROM fitted the serial line carries data, not a strap
         // The wide part keeps its width even when configuration comes from EEPROM
         width <= (i_eeprom_present_strap && !IS_32BIT) ? hbp_pkg::HBP_W16 : strap_width;
      end
   end

   // Serial configuration shift-in, only when the EEPROM is used
   always_ff @(posedge i_clk_sys or negedge i_hw_reset_n) begin
      if (!i_hw_reset_n) begin
         ee_data <= hbp_pkg::EEDATA_RST;
      end else if (ee_strap && i_ee_shift) begin
         ee_data <= {ee_data[14:0], i_eeprom_serial_in};
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_hw_reset_n) begin
      if (!i_hw_reset_n) begin
         latch_en <= hbp_pkg::CTRL_LATCH_RST;
         base <= hbp_pkg::BASE_RST;
      end else begin
         if (wr_ctrl) begin
            latch_en <= i_reg_wdata[hbp_pkg::CTRL_LATCH_BIT];
         end
         if (wr_base) begin
            base <= i_reg_wdata[15:4];
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_hw_reset_n) begin
      if (!i_hw_reset_n) begin
         lat_addr <= 15'h0000;
         lat_qual_n <= 1'b1;
      end else if (ads_rise) begin
         lat_addr <= i_addr;
         lat_qual_n <= i_addr_qualifier_n;
      end
   end

   // Previous strobe levels start high, so a write or read strobe low at release counts as a falling edge; an address strobe high at release is no rise
   always_ff @(posedge i_clk_sys or negedge i_hw_reset_n) begin
      if (!i_hw_reset_n) begin
         ads_prev <= 1'b1;
         wr_prev <= 1'b1;
         rd_prev <= 1'b1;
         acc <= '0;
         rdata <= 16'h0000;
      end else begin
         ads_prev <= i_addr_latch_strobe_n;
         wr_prev <= i_write_strobe_n;
         rd_prev <= i_read_strobe_n;
         acc.wr <= next_wr;
         acc.rd <= next_rd;
         if (next_wr || next_rd) acc.addr <= dec_addr;
         rdata <= next_rdata;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_hw_reset_n);

   a_sel_needs_qual: assert property (!o_local_select_n |-> !dec_qual_n)
      else $error("select active with qualifier high");
   a_sel_base_match: assert property (!o_local_select_n |-> dec_addr[15:4] == base)
      else $error("select active without base match");
   a_sync_write: assert property (i_sync_req && i_sync_dir && hit && i_chip_sleep_n
      |=> o_acc.wr && !o_acc.rd)
      else $error("sync write not issued");
   a_async_write: assert property ($fell(i_write_strobe_n) && hit && i_chip_sleep_n
      |=> o_acc.wr)
      else $error("async write not issued");
   a_async_read: assert property ($fell(i_read_strobe_n) && hit && i_chip_sleep_n
      |=> o_acc.rd)
      else $error("async read not issued");
   a_sleep_blocks: assert property (!i_chip_sleep_n |=> !o_acc.wr && !o_acc.rd)
      else $error("access during power-down");
   a_latch_capture: assert property ($rose(i_addr_latch_strobe_n)
      |=> lat_addr == $past(i_addr) && lat_qual_n == $past(i_addr_qualifier_n))
      else $error("address not latched on strobe rise");
   a_latch_hold: assert property (latch_en && !$rose(i_addr_latch_strobe_n)
      |=> $stable(lat_addr))
      else $error("latched address moved without strobe");
   a_transparent_path: assert property (!latch_en |-> dec_addr == i_addr)
      else $error("address not transparent");
   a_width_strap: assert property (straps_taken && !ee_strap && !IS_32BIT
      |-> o_bus_width != hbp_pkg::HBP_W32)
      else $error("bus width outside 8/16 on 16-bit part");
   a_ee_shift: assert property (ee_strap && i_ee_shift
      |=> ee_data[0] == $past(i_eeprom_serial_in))
      else $error("EEPROM bit not shifted in");

   // Select decode, both directions
   a_sel_on_match: assert property (!dec_qual_n && dec_addr[15:4] == base
      |-> !o_local_select_n)
      else $error("select missing on base match");

   a_refuse_qual: assert property (dec_qual_n
      |=> !o_acc.wr && !o_acc.rd)
      else $error("access taken with qualifier high");

   a_refuse_base: assert property (dec_addr[15:4] != base
      |=> !o_acc.wr && !o_acc.rd)
      else $error("access taken without base match");

   a_sleep_output: assert property (o_sleep == !i_chip_sleep_n)
      else $error("sleep output wrong");

   // Every access pulse needs a cause one cycle earlier
   a_wr_has_cause: assert property (o_acc.wr
      |-> $past(hit && i_chip_sleep_n))
      else $error("write pulse without select");

   a_rd_has_cause: assert property (o_acc.rd
      |-> $past(hit && i_chip_sleep_n))
      else $error("read pulse without select");

   a_wr_needs_strobe: assert property (o_acc.wr
      |-> $past(i_sync_req && i_sync_dir) || $past(!i_write_strobe_n))
      else $error("write pulse without request");

   a_rd_needs_strobe: assert property (o_acc.rd
      |-> $past(i_sync_req && !i_sync_dir) || $past(!i_read_strobe_n))
      else $error("read pulse without request");

   a_sync_read: assert property (i_sync_req && !i_sync_dir && hit && i_chip_sleep_n
      |=> o_acc.rd)
      else $error("sync read not issued");

   a_acc_addr: assert property (next_wr || next_rd
      |=> o_acc.addr == $past(dec_addr))
      else $error("access address wrong");

   a_acc_addr_hold: assert property (!next_wr && !next_rd
      |=> $stable(o_acc.addr))
      else $error("access address moved while idle");

   a_qual_latch_hold: assert property (!$rose(i_addr_latch_strobe_n)
      |=> $stable(lat_qual_n))
      else $error("latched qualifier moved without strobe");

   // Straps are taken once and then frozen
   a_straps_first: assert property (!straps_taken
      |=> straps_taken)
      else $error("straps not taken after reset");

   a_straps_frozen: assert property (straps_taken
      |=> $stable(ee_strap) && $stable(width))
      else $error("strap values moved");

   a_ee_strap_take: assert property (!straps_taken
      |=> o_eeprom_used == $past(i_eeprom_present_strap))
      else $error("EEPROM strap not captured");

   a_width_pick: assert property (!straps_taken && !i_eeprom_present_strap && !IS_32BIT
      |=> o_bus_width == ($past(i_eeprom_serial_in) ? hbp_pkg::HBP_W16 : hbp_pkg::HBP_W8))
      else $error("bus width strap not honoured");

   a_width_wide: assert property (IS_32BIT && straps_taken
      |-> o_bus_width == hbp_pkg::HBP_W32)
      else $error("wide part width not fixed");

   a_ee_idle: assert property (!(ee_strap && i_ee_shift)
      |=> $stable(ee_data))
      else $error("EEPROM data moved without shift");

   // Register port
   a_ctrl_write: assert property (wr_ctrl
      |=> latch_en == $past(i_reg_wdata[hbp_pkg::CTRL_LATCH_BIT]))
      else $error("control write lost");

   a_base_write: assert property (wr_base
      |=> base == $past(i_reg_wdata[15:4]))
      else $error("base write lost");

   a_rdata_idle: assert property (!i_reg_rd
      |=> o_reg_rdata == 16'h0000)
      else $error("read data outside read slot");

   a_rdata_base: assert property (i_reg_rd && i_reg_addr == hbp_pkg::REG_BASE
      |=> o_reg_rdata == {$past(base), 4'h0})
      else $error("base read wrong");

   a_rdata_ctrl: assert property (i_reg_rd && i_reg_addr == hbp_pkg::REG_CTRL
      |=> o_reg_rdata == {15'h0000, $past(latch_en)})
      else $error("control read wrong");

   a_rdata_unmapped: assert property (i_reg_rd && i_reg_addr != hbp_pkg::REG_CTRL
      && i_reg_addr != hbp_pkg::REG_BASE && i_reg_addr != hbp_pkg::REG_STAT
      && i_reg_addr != hbp_pkg::REG_EEDATA |=> o_reg_rdata == 16'h0000)
      else $error("unmapped read not zero");


   c_sync_read: cover property (i_sync_req && !i_sync_dir ##1 o_acc.rd);
   c_async_write: cover property ($fell(i_write_strobe_n) ##1 o_acc.wr);
   c_latched_hit: cover property (latch_en && $rose(i_addr_latch_strobe_n) ##1 hit);
   c_sleep_hit: cover property (hit && !i_chip_sleep_n);
   c_sync_write: cover property (i_sync_req && i_sync_dir && hit ##1 o_acc.wr);
endmodule

// file: hdl/hbp_pkg.sv
// Shared constants and types for the host bus pin control block
package hbp_pkg;
   // Register word addresses (byte offsets on the register port)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BASE = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_EEDATA = 8'h0c;
   // Field positions
   localparam int CTRL_LATCH_BIT = 0;
   localparam int STAT_EE_BIT = 0;
   localparam int STAT_WIDTH_LSB = 1;
   localparam int STAT_SLEEP_BIT = 3;
   localparam int STAT_QUAL_BIT = 4;
   // Reset values
   localparam logic CTRL_LATCH_RST = 1'b0;
   localparam logic [11:0] BASE_RST = 12'h030;
   localparam logic [15:0] EEDATA_RST = 16'h0000;
   // Reset hold demanded of the system, and its figure in clock cycles
   localparam int RESET_HOLD_MS = 10;
   localparam int CLK_HZ = 25_000_000;
   localparam int RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);

   typedef enum logic [1:0] {HBP_W8, HBP_W16, HBP_W32} hbp_width_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:1] addr;
   } hbp_acc_t;
endpackage

// file: verification/hbp_host_model.sv
// Host processor model that drives the address, qualifier and strobe pins
module hbp_host_model (
   input wire logic i_clk_sys,
   input wire hbp_pkg::hbp_acc_t i_acc,
   output logic [15:1] o_addr,
   output logic o_addr_qualifier_n,
   output logic o_addr_latch_strobe_n,
   output logic o_write_strobe_n,
   output logic o_read_strobe_n,
   output logic o_sync_req,
   output logic o_sync_dir
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_addr = '0;
      {o_addr_qualifier_n, o_addr_latch_strobe_n, o_write_strobe_n, o_read_strobe_n} = 4'hf;
      {o_sync_req, o_sync_dir} = 2'h0;
   end
   task automatic put(input logic [15:0] a, input logic q);
      @(posedge i_clk_sys);
      o_addr <= a[15:1];
      o_addr_qualifier_n <= q;
   endtask
   // Pins move right after capture, so a late sample would see garbage
   task automatic latch(input logic [15:0] a);
      put(a, 1'b0);
      o_addr_latch_strobe_n <= 1'b0;
      @(posedge i_clk_sys);
      o_addr_latch_strobe_n <= 1'b1;
      put(~a, 1'b1);
   endtask
   // Kind 0 async write, 1 async read, 2 sync write, 3 sync read
   task automatic cycle(input logic [1:0] kind, output hbp_pkg::hbp_acc_t seen);
      @(posedge i_clk_sys);
      o_write_strobe_n <= (kind != 2'h0);
      o_read_strobe_n <= (kind != 2'h1);
      o_sync_req <= kind[1];
      o_sync_dir <= (kind == 2'h2);
      seen = '0;
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk_sys);
         o_sync_req <= 1'b0;
         #1;
         if (i_acc.wr === 1'b1 || i_acc.rd === 1'b1) seen = i_acc;
      end
      @(posedge i_clk_sys);
      {o_write_strobe_n, o_read_strobe_n} <= 2'h3;
   endtask
endmodule

// file: verification/tb.sv
// Self-checking testbench for the host port block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys, i_hw_reset_n, i_chip_sleep_n, i_eeprom_present_strap, i_eeprom_serial_in;
   logic i_ee_shift, i_reg_wr, i_reg_rd, o_local_select_n, o_eeprom_used, o_sleep;
   logic i_addr_qualifier_n, i_addr_latch_strobe_n, i_write_strobe_n, i_read_strobe_n;
   logic i_sync_req, i_sync_dir;
   logic [15:1] i_addr;
   logic [7:0] i_reg_addr;
   logic [15:0] i_reg_wdata, o_reg_rdata;
   hbp_pkg::hbp_acc_t o_acc, seen;
   hbp_pkg::hbp_width_t o_bus_width;
   int error_cnt = 0;
   int checks = 0;
   hbp_host_port i_dut (.i_clk_sys, .i_hw_reset_n, .i_addr, .i_addr_qualifier_n,
      .i_addr_latch_strobe_n, .i_write_strobe_n, .i_read_strobe_n, .i_sync_req, .i_sync_dir,
      .i_chip_sleep_n, .i_eeprom_present_strap, .i_eeprom_serial_in, .i_ee_shift,
      .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_local_select_n,
      .o_acc, .o_bus_width, .o_eeprom_used, .o_sleep);
   hbp_host_model i_host (.i_clk_sys, .i_acc(o_acc), .o_addr(i_addr),
      .o_addr_qualifier_n(i_addr_qualifier_n), .o_addr_latch_strobe_n(i_addr_latch_strobe_n),
      .o_write_strobe_n(i_write_strobe_n), .o_read_strobe_n(i_read_strobe_n),
      .o_sync_req(i_sync_req), .o_sync_dir(i_sync_dir));
   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   task automatic check(input string name, input logic [16:0] val, input logic [16:0] exp);
      checks++;
      if (val !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, val);
      end
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
      @(posedge i_clk_sys);
      {i_reg_addr, i_reg_rd} <= {a, 1'b1};
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      #1 check(name, o_reg_rdata, exp);
   endtask
   // Reset well beyond one edge; the real part needs far longer
   task automatic do_reset();
      i_hw_reset_n <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
      i_hw_reset_n <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic sel(input logic [15:0] a, input logic q, input logic exp);
      i_host.put(a, q);
      #1 check("select", o_local_select_n, exp);
   endtask
   initial begin
      {i_chip_sleep_n, i_eeprom_present_strap, i_eeprom_serial_in, i_ee_shift} = 4'ha;
      {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = '0;
      i_hw_reset_n = 1'b0;
      do_reset();
      check("width", o_bus_width, hbp_pkg::HBP_W16);
      check("ee_used", o_eeprom_used, 1'b0);
      rd(hbp_pkg::REG_BASE, 16'h0300, "base");
      rd(8'hfe, 16'h0000, "unmapped");
      sel(16'h0300, 1'b0, 1'b0);
      sel(16'h0310, 1'b0, 1'b1);
      sel(16'h0302, 1'b1, 1'b1);
      i_host.cycle(2'h0, seen);
      check("refused", seen, '0);
      sel(16'h0302, 1'b0, 1'b0);
      // Walk all four access kinds, async and sync
      for (int k = 0; k < 4; k++) begin
         i_host.cycle(k[1:0], seen);
         check("access", seen, {~k[0], k[0], 15'h0181});
      end
      i_chip_sleep_n <= 1'b0;
      i_host.cycle(2'h0, seen);
      check("sleep", o_sleep, 1'b1);
      check("sleep_acc", seen, '0);
      i_chip_sleep_n <= 1'b1;
      wr(hbp_pkg::REG_BASE, 16'h1230);
      wr(hbp_pkg::REG_CTRL, 16'h0001);
      i_host.latch(16'h1238);
      #1 check("latched", o_local_select_n, 1'b0);
      i_host.cycle(2'h1, seen);
      check("latch_acc", seen, {2'b01, 15'h091c});
      wr(hbp_pkg::REG_CTRL, 16'h0000);
      #1 check("transp", o_local_select_n, 1'b1);
      i_eeprom_present_strap <= 1'b1;
      do_reset();
      check("ee_used", o_eeprom_used, 1'b1);
      rd(hbp_pkg::REG_STAT, 16'h0013, "stat");
      for (int b = 0; b < 3; b++) begin
         @(posedge i_clk_sys);
         {i_eeprom_serial_in, i_ee_shift} <= {b[0] == 1'b0, 1'b1};
         @(posedge i_clk_sys);
         i_ee_shift <= 1'b0;
      end
      rd(hbp_pkg::REG_EEDATA, 16'h0005, "eedata");
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge i_clk_sys);
      error_cnt++;
      end_sim();
   end
endmodule
